// >>> hw/dacoc_regs.sv
// Output control registers and sample path for a 12-channel converter.
// Avalon-MM slave with waitrequest; byte addresses are index times four.
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/1ps
`include "dacoc_params.svh"

module dacoc_regs
	import dacoc_pkg::*;
#(
	parameter int NCH = 12
) (
	input  wire logic        ref_clk,          // 200 MHz block clock
	input  wire logic        sys_rst,          // Async reset, high
	input  wire logic        clk_en,           // Freezes all state when low
	input  wire logic [7:0]  avs_address,      // Byte address
	input  wire logic        avs_read,         // Read request
	input  wire logic        avs_write,        // Write request
	input  wire logic [3:0]  avs_byteenable,   // Byte lanes
	input  wire logic [31:0] avs_writedata,    // Write data
	output logic [31:0]      avs_readdata,     // Read data
	output logic             avs_waitrequest,  // Stall
	input  wire logic        in_valid,         // Sample strobe
	input  wire logic [3:0]  in_ch,            // Channel 0..11
	input  wire dacoc_sample_t in_data,        // Sample value
	output logic             out_valid,        // Output strobe
	output logic [3:0]       out_ch,           // Output channel
	output dacoc_sample_t    out_data,         // Processed sample
	output logic [5:0]       tdm_slot_bits,    // Bit clocks per slot
	output logic [8:0]       oversample_ratio  // Converter rate / fs
);

	// Register state
	logic [7:0]  ctrl2_q, ctrl2_d;
	logic [7:0]  mute_lo_q, mute_lo_d;
	logic [7:0]  mute_hi_q, mute_hi_d;
	dacoc_att_t  master_q, master_d;
	dacoc_att_t  ch1_att_q, ch1_att_d;
	dacoc_att_t  ch2_att_q, ch2_att_d;
	dacoc_bus_e  bus_q, bus_d;
	logic [31:0] rdata_q, rdata_d;

	// Sample path state
	logic            ov_q, ov_d;
	logic [3:0]      och_q, och_d;
	dacoc_sample_t   odata_q, odata_d;
	dacoc_sample_t   emph_q [NCH];
	dacoc_sample_t   emph_d [NCH];

	logic [5:0]      idx;
	logic            wr_go;
	logic            tdm_narrow;
	logic            invert;
	logic            amute_en;
	logic            osr_low;
	logic            emph_en;
	logic [11:0]     soft_mute;
	logic [11:0]     auto_mute;
	logic            ch_ok;
	dacoc_sample_t   filt;
	dacoc_sample_t   atten_out;
	dacoc_att_t      total_att;

	assign idx        = avs_address[7:2];
	assign tdm_narrow = ctrl2_q[`DACOC_BIT_SLOTW];
	assign invert     = ctrl2_q[`DACOC_BIT_INVERT];
	assign amute_en   = ctrl2_q[`DACOC_BIT_AMUTE];
	assign osr_low    = ctrl2_q[`DACOC_BIT_OSR];
	assign emph_en    = ctrl2_q[`DACOC_BIT_EMPH];
	assign soft_mute  = {mute_hi_q[3:0], mute_lo_q};
	assign ch_ok      = in_valid && (in_ch < 4'(NCH));

	// Channel's own attenuation; only channels 1 and 2 have one
	function automatic dacoc_att_t own_att(input logic [3:0] ch,
		input dacoc_att_t a1, input dacoc_att_t a2);
		if (ch == 4'h0)
			own_att = a1;
		else if (ch == 4'h1)
			own_att = a2;
		else
			own_att = 8'h00;
	endfunction : own_att

	// Register read multiplexer
	function automatic logic [31:0] rd_mux(input logic [5:0] i,
		input logic [7:0] c2, input logic [7:0] ml, input logic [7:0] mh,
		input dacoc_att_t ma, input dacoc_att_t a1, input dacoc_att_t a2,
		input logic [11:0] am);
		unique case (i)
			`DACOC_IDX_CTRL2:   rd_mux = {24'h0, c2};
			`DACOC_IDX_MUTE_LO: rd_mux = {24'h0, ml};
			`DACOC_IDX_MUTE_HI: rd_mux = {24'h0, mh};
			`DACOC_IDX_MASTER:  rd_mux = {24'h0, ma};
			`DACOC_IDX_CH1:     rd_mux = {24'h0, a1};
			`DACOC_IDX_CH2:     rd_mux = {24'h0, a2};
			`DACOC_IDX_AM_STAT: rd_mux = {20'h0, am};
			default:            rd_mux = 32'h0;
		endcase
	endfunction : rd_mux

	// Bus handshake: one stall cycle, then the access completes
	always_comb begin
		bus_d   = bus_q;
		rdata_d = rdata_q;
		unique case (bus_q)
			BUS_IDLE: begin
				if (avs_read || avs_write) begin
					bus_d   = BUS_DONE;
					rdata_d = avs_read ? rd_mux(idx, ctrl2_q, mute_lo_q,
						mute_hi_q, master_q, ch1_att_q, ch2_att_q,
						auto_mute) : rdata_q;
				end
			end
			BUS_DONE: bus_d = BUS_IDLE;
		endcase
	end

	// Stall while frozen too, or a pending write would complete unstored
	assign avs_waitrequest = (avs_read || avs_write) &&
		(!clk_en || bus_q != BUS_DONE);
	assign avs_readdata    = rdata_q;
	assign wr_go = avs_write && (bus_q == BUS_DONE) && avs_byteenable[0];

	// Register writes
	always_comb begin
		ctrl2_d   = ctrl2_q;
		mute_lo_d = mute_lo_q;
		mute_hi_d = mute_hi_q;
		master_d  = master_q;
		ch1_att_d = ch1_att_q;
		ch2_att_d = ch2_att_q;
		if (wr_go) begin
			unique case (idx)
				`DACOC_IDX_CTRL2:
					ctrl2_d = avs_writedata[7:0] & `DACOC_MASK_CTRL2;
				`DACOC_IDX_MUTE_LO: mute_lo_d = avs_writedata[7:0];
				`DACOC_IDX_MUTE_HI:
					mute_hi_d = avs_writedata[7:0] & `DACOC_MASK_MUTE_HI;
				`DACOC_IDX_MASTER:  master_d  = avs_writedata[7:0];
				`DACOC_IDX_CH1:     ch1_att_d = avs_writedata[7:0];
				`DACOC_IDX_CH2:     ch2_att_d = avs_writedata[7:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			bus_q     <= BUS_IDLE;
			rdata_q   <= 32'h0;
			ctrl2_q   <= `DACOC_RST_CTRL2;
			mute_lo_q <= `DACOC_RST_MUTE;
			mute_hi_q <= `DACOC_RST_MUTE;
			master_q  <= `DACOC_RST_ATT;
			ch1_att_q <= `DACOC_RST_ATT;
			ch2_att_q <= `DACOC_RST_ATT;
		end else if (clk_en) begin
			bus_q     <= bus_d;
			rdata_q   <= rdata_d;
			ctrl2_q   <= ctrl2_d;
			mute_lo_q <= mute_lo_d;
			mute_hi_q <= mute_hi_d;
			master_q  <= master_d;
			ch1_att_q <= ch1_att_d;
			ch2_att_q <= ch2_att_d;
		end
	end

	// Mode outputs for the serial port and modulator clocking
	assign tdm_slot_bits = tdm_narrow ? `DACOC_SLOT_NARROW
		: `DACOC_SLOT_WIDE;
	assign oversample_ratio = osr_low ? `DACOC_OSR_LOW
		: `DACOC_OSR_HIGH;

	// Automute detector
	dacoc_mute_if mif ();
	assign mif.valid = ch_ok;
	assign mif.ch    = in_ch;
	assign mif.zero  = (in_data == '0);
	assign mif.en    = amute_en;
	assign auto_mute = mif.muted;

	dacoc_zero_det #(
		.NCH     (NCH)
	) u_zero (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.clk_en  (clk_en),
		.mi      (mif)
	);

	// Master plus channel code, clamped at full attenuation
	always_comb begin
		logic [8:0] sum;
		sum = 9'(master_q) + 9'(own_att(in_ch, ch1_att_q, ch2_att_q));
		total_att = (sum > `DACOC_ATT_MAX) ? 8'hFF : sum[7:0];
	end

	dacoc_atten u_att (
		.din  (filt),
		.code (total_att),
		.dout (atten_out)
	);

	// One-pole treble cut per channel; tracks input when disabled
	always_comb begin
		dacoc_sample_t prev;
		prev = '0;
		for (int c = 0; c < NCH; c++)
			emph_d[c] = emph_q[c];
		filt = in_data;
		if (ch_ok) begin
			for (int c = 0; c < NCH; c++) begin
				if (in_ch == 4'(c))
					prev = emph_q[c];
			end
			if (emph_en)
				filt = prev + ((in_data - prev) >>> `DACOC_EMPH_SHIFT);
			for (int c = 0; c < NCH; c++) begin
				if (in_ch == 4'(c))
					emph_d[c] = filt;
			end
		end
	end

	// Output stage: polarity, then soft mute and automute
	always_comb begin
		dacoc_sample_t v;
		v       = atten_out;
		ov_d    = ch_ok;
		och_d   = ch_ok ? in_ch : och_q;
		odata_d = odata_q;
		if (invert)
			v = (atten_out == 24'sh800000) ? 24'sh7FFFFF : -atten_out;
		if (ch_ok) begin
			if (soft_mute[in_ch] || auto_mute[in_ch])
				odata_d = '0;
			else
				odata_d = v;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ov_q    <= 1'b0;
			och_q   <= 4'h0;
			odata_q <= '0;
			for (int c = 0; c < NCH; c++)
				emph_q[c] <= '0;
		end else if (clk_en) begin
			ov_q    <= ov_d;
			och_q   <= och_d;
			odata_q <= odata_d;
			for (int c = 0; c < NCH; c++)
				emph_q[c] <= emph_d[c];
		end
	end

	assign out_valid = ov_q;
	assign out_ch    = och_q;
	assign out_data  = odata_q;

endmodule : dacoc_regs

// >>> hw/dacoc_params.svh
// Register offsets, field positions, reset values and counts for the
// converter output control block. Included by the package and modules.
//
// Function
// - A TDM channel slot is 32 bit clocks when the slot width bit is 0 and 16 when it is 1.
// - The output invert bit flips the polarity of every channel together; clear leaves them normal.
// - With automute enabled a channel mutes after 1024 consecutive zero samples; clearing the bit stops it.
// - Zero runs are counted and automute applied separately for each channel.
// - Converters run at 256 times the sample rate when the oversample bit is 0 and 128 times when 1.
// - Bits 0 to 7 of the low mute register soft-mute channels 1 to 8 when set.
// - Bits 0 to 3 of the high mute register soft-mute channels 9 to 12 when set.
// - Each attenuation code lowers the level by 0.375 dB per unit, code zero meaning none.
// - Master attenuation runs from code 00 at 0 dB to code FF at 95.625 dB.
// - Channels 1 and 2 each have an 8-bit attenuation register on the same scale, reset 0 dB.
`ifndef DACOC_PARAMS_SVH
`define DACOC_PARAMS_SVH

// Register indices; byte address is four times the index
`define DACOC_IDX_CTRL2      6'h08
`define DACOC_IDX_MUTE_LO    6'h09
`define DACOC_IDX_MUTE_HI    6'h0A
`define DACOC_IDX_MASTER     6'h0B
`define DACOC_IDX_CH1        6'h0C
`define DACOC_IDX_CH2        6'h0D
`define DACOC_IDX_AM_STAT    6'h20

// Reset values
`define DACOC_RST_CTRL2      8'h06
`define DACOC_RST_MUTE       8'h00
`define DACOC_RST_ATT        8'h00

// Writable bit masks
`define DACOC_MASK_CTRL2     8'h1F
`define DACOC_MASK_MUTE_HI   8'h0F

// Control field positions
`define DACOC_BIT_SLOTW      4
`define DACOC_BIT_INVERT     3
`define DACOC_BIT_AMUTE      2
`define DACOC_BIT_OSR        1
`define DACOC_BIT_EMPH       0

// Slot widths and oversampling ratios
`define DACOC_SLOT_WIDE      6'd32
`define DACOC_SLOT_NARROW    6'd16
`define DACOC_OSR_HIGH       9'd256
`define DACOC_OSR_LOW        9'd128

// Automute run length, attenuation limits and treble-cut filter shift
`define DACOC_ZERO_RUN       11'd1024
`define DACOC_ATT_MAX        9'h0FF
`define DACOC_STEPS_PER_SHIFT 4
`define DACOC_EMPH_SHIFT     2

`endif

// >>> hw/dacoc_pkg.sv
// Types shared by the converter output control block.
// Assumes dacoc_params.svh is on the include path.
`include "dacoc_params.svh"

package dacoc_pkg;

	typedef enum logic [0:0] {
		BUS_IDLE = 1'b0,
		BUS_DONE = 1'b1
	} dacoc_bus_e;

	typedef logic signed [23:0] dacoc_sample_t;
	typedef logic [7:0]         dacoc_att_t;

endpackage : dacoc_pkg

// >>> hw/dacoc_mute_if.sv
// Carrier between the sample path and the per-channel zero-run detector.
// Assumes both ends share ref_clk.
`timescale 1ns/1ps

interface dacoc_mute_if;
	import dacoc_pkg::*;
	logic        valid;
	logic [3:0]  ch;
	logic        zero;
	logic        en;
	logic [11:0] muted;

	modport src (output valid, output ch, output zero, output en,
		input muted);
	modport det (input valid, input ch, input zero, input en,
		output muted);
endinterface : dacoc_mute_if

// >>> hw/dacoc_zero_det.sv
// Per-channel zero-run counters that raise the automute flags.
// Assumes channel numbers 0 to NCH-1 on the carrier; others are ignored.
`timescale 1ns/1ps
`include "dacoc_params.svh"

module dacoc_zero_det
	import dacoc_pkg::*;
#(
	parameter int NCH = 12
) (
	input  wire logic    ref_clk,  // Block clock
	input  wire logic    sys_rst,  // Async reset, high
	input  wire logic    clk_en,   // Freezes state when low
	dacoc_mute_if.det    mi        // Sample events in, flags out
);

	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_ch
			logic [10:0] run_q;
			logic [10:0] run_d;

			always_comb begin
				run_d = run_q;
				// Each channel counts only its own samples
				if (mi.valid && mi.ch == 4'(g)) begin
					if (!mi.zero)
						run_d = '0;
					else if (run_q != `DACOC_ZERO_RUN)
						run_d = run_q + 11'd1;
				end
			end

			always_ff @(posedge ref_clk or posedge sys_rst) begin
				if (sys_rst)
					run_q <= '0;
				else if (clk_en)
					run_q <= run_d;
			end

			assign mi.muted[g] = mi.en && (run_q == `DACOC_ZERO_RUN);
		end
	endgenerate

endmodule : dacoc_zero_det

// >>> hw/dacoc_atten.sv
// Log attenuator: 0.375 dB per code step, 16 steps taken as one shift.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`include "dacoc_params.svh"

module dacoc_atten
	import dacoc_pkg::*;
(
	input  wire dacoc_sample_t din,   // Sample in
	input  wire logic [7:0]    code,  // Attenuation code
	output dacoc_sample_t      dout   // Attenuated sample
);

	// Fine gain for code modulo 16, unsigned Q16
	function automatic logic [16:0] fine_gain(input logic [3:0] k);
		unique case (k)
			4'h0: fine_gain = 17'h10000;
			4'h1: fine_gain = 17'h0F530;
			4'h2: fine_gain = 17'h0EAD5;
			4'h3: fine_gain = 17'h0E0EA;
			4'h4: fine_gain = 17'h0D76A;
			4'h5: fine_gain = 17'h0CE51;
			4'h6: fine_gain = 17'h0C59A;
			4'h7: fine_gain = 17'h0BD42;
			4'h8: fine_gain = 17'h0B544;
			4'h9: fine_gain = 17'h0AD9C;
			4'hA: fine_gain = 17'h0A647;
			4'hB: fine_gain = 17'h09F41;
			4'hC: fine_gain = 17'h09888;
			4'hD: fine_gain = 17'h09217;
			4'hE: fine_gain = 17'h08BEB;
			4'hF: fine_gain = 17'h08602;
		endcase
	endfunction : fine_gain

	logic signed [41:0] prod;
	logic signed [41:0] scaled;

	always_comb begin
		prod   = $signed(42'(din)) * $signed({25'h0, fine_gain(code[3:0])});
		scaled = prod >>> (16 + 32'(code >> `DACOC_STEPS_PER_SHIFT));
		dout   = dacoc_sample_t'(scaled);
	end

endmodule : dacoc_atten

// >>> test/dacoc_regs_monitor.sv
// Assertions on the ports of the output control block.
// Assumes it is bound into dacoc_regs with one clock.
`timescale 1ns/1ps

module dacoc_mon
	import dacoc_pkg::*;
#(
	parameter int NCH = 12
) (
	input wire logic          ref_clk,          // Clock
	input wire logic          sys_rst,          // Reset
	input wire logic          clk_en,           // Enable
	input wire logic [7:0]    avs_address,      // Address
	input wire logic          avs_read,         // Read
	input wire logic          avs_write,        // Write
	input wire logic [3:0]    avs_byteenable,   // Lanes
	input wire logic [31:0]   avs_writedata,    // Write data
	input wire logic [31:0]   avs_readdata,     // Read data
	input wire logic          avs_waitrequest,  // Stall
	input wire logic          in_valid,         // Sample in
	input wire logic [3:0]    in_ch,            // Channel in
	input wire dacoc_sample_t in_data,          // Data in
	input wire logic          out_valid,        // Sample out
	input wire logic [3:0]    out_ch,           // Channel out
	input wire dacoc_sample_t out_data,         // Data out
	input wire logic [5:0]    tdm_slot_bits,    // Slot width
	input wire logic [8:0]    oversample_ratio  // Rate ratio
);
	logic ctl_wr;
	logic smp_ok;

	assign ctl_wr = clk_en && avs_write && !avs_waitrequest &&
		avs_address == 8'h20 && avs_byteenable[0];
	assign smp_ok = clk_en && in_valid && in_ch < NCH;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	slot_width_a: assert property (ctl_wr |=> tdm_slot_bits ==
		($past(avs_writedata[4]) ? 6'h10 : 6'h20))
		else $error("slot width does not follow control write");
	over_ratio_a: assert property (ctl_wr |=> oversample_ratio ==
		($past(avs_writedata[1]) ? 9'h080 : 9'h100))
		else $error("ratio does not follow control write");
	out_pulse_a: assert property (smp_ok |=>
		out_valid && out_ch == $past(in_ch))
		else $error("sample not answered next cycle");
	out_none_a: assert property (clk_en && !smp_ok |=> !out_valid)
		else $error("output strobe without sample");
	wait_one_a: assert property (clk_en && (avs_read || avs_write) &&
		avs_waitrequest |=> !avs_waitrequest || !clk_en)
		else $error("bus stall longer than one cycle");
	frz_wait_a: assert property (!clk_en && (avs_read || avs_write) |->
		avs_waitrequest)
		else $error("bus answered while enable low");
	wait_first_a: assert property ($rose(avs_read) |-> avs_waitrequest)
		else $error("read answered without wait cycle");
	idle_wait_a: assert property (!avs_read && !avs_write |->
		!avs_waitrequest)
		else $error("stall while bus idle");
	rdata_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
		else $error("read data changed without read");
	ch_hold_a: assert property (!out_valid |-> $stable(out_ch))
		else $error("output channel changed without strobe");

	cover property (ctl_wr);
	cover property (avs_read && !avs_waitrequest);
	cover property (out_valid ##1 out_valid);
	cover property (!clk_en && avs_waitrequest);
endmodule : dacoc_mon

// >>> test/dacoc_regs_tb.sv
// Self-checking bench for the output control registers.
// Assumes dacoc_regs and dacoc_mon are compiled beforehand.
`timescale 1ns/1ps

module dacoc_regs_tb;
	import dacoc_pkg::*;
	logic          ref_clk, sys_rst, clk_en;
	logic [7:0]    avs_address;
	logic          avs_read, avs_write, avs_waitrequest;
	logic [3:0]    avs_byteenable;
	logic [31:0]   avs_writedata, avs_readdata;
	logic          in_valid, out_valid;
	logic [3:0]    in_ch, out_ch;
	dacoc_sample_t in_data, out_data;
	logic [5:0]    tdm_slot_bits;
	logic [8:0]    oversample_ratio;
	int            errors, compares;
	logic [7:0]    rv [6] = '{8'h06, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0]    mk [6] = '{8'h1F, 8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'hFF};

	dacoc_regs #(.NCH(12)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.clk_en(clk_en), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_byteenable(avs_byteenable),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .in_valid(in_valid),
		.in_ch(in_ch), .in_data(in_data), .out_valid(out_valid),
		.out_ch(out_ch), .out_data(out_data),
		.tdm_slot_bits(tdm_slot_bits), .oversample_ratio(oversample_ratio));

	always #2.5 ref_clk = ~ref_clk;

	task automatic test_done;
		$display("compares=%0d errors=%0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : test_done

	task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %0t value %h expected %h", $time, g, e);
		end
	endtask : chk_val

	task automatic chk_smp(input dacoc_sample_t g, input dacoc_sample_t e);
		compares++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %0t sample %h expected %h", $time, g, e);
		end
	endtask : chk_smp

	task automatic bus(input logic w, input logic [7:0] a,
		input logic [7:0] d, output logic [31:0] q);
		int n;
		n = 0;
		avs_address   <= a;
		avs_writedata <= {24'h000000, d};
		avs_write     <= w;
		avs_read      <= !w;
		@(posedge ref_clk);
		while (avs_waitrequest !== 1'b0 && n < 50) begin
			n++;
			@(posedge ref_clk);
		end
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
		@(posedge ref_clk);
		if (n == 50) begin
			errors++;
			$display("[ERR] %0t bus timeout", $time);
			test_done();
		end
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		logic [31:0] q;
		bus(1'b0, a, 8'h00, q);
		chk_val(q, {24'h000000, e});
	endtask : rd_chk

	// One sample in, compare the strobe and value one cycle later
	task automatic smp(input logic [3:0] c, input dacoc_sample_t x,
		input dacoc_sample_t e);
		in_valid <= 1'b1;
		in_ch    <= c;
		in_data  <= x;
		@(posedge ref_clk);
		in_valid <= 1'b0;
		@(posedge ref_clk);
		chk_val({31'h0, out_valid}, 32'h1);
		chk_smp(out_data, e);
	endtask : smp

	// Enable drops while a write is pending; the bus must stall until it
	// returns, and the write must still land
	task automatic frz_wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		fork
			bus(1'b1, a, d, q);
			begin
				@(posedge ref_clk);
				clk_en <= 1'b0;
				repeat (2) @(posedge ref_clk);
				clk_en <= 1'b1;
			end
		join
	endtask : frz_wr

	task automatic zrun(input logic [3:0] c, input int n);
		in_valid <= 1'b1;
		in_ch    <= c;
		in_data  <= 24'h000000;
		repeat (n) @(posedge ref_clk);
		in_valid <= 1'b0;
		@(posedge ref_clk);
	endtask : zrun

	initial begin
		ref_clk = 1'b0;
		sys_rst = 1'b1;
		clk_en = 1'b1;
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_byteenable = 4'hF;
		avs_writedata = 32'h0;
		in_valid = 1'b0;
		in_ch = 4'h0;
		in_data = 24'h000000;
		errors = 0;
		compares = 0;
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		chk_val(32'(tdm_slot_bits), 32'h20);
		chk_val(32'(oversample_ratio), 32'h80);
		for (int i = 0; i < 6; i++) begin
			rd_chk(8'h20 + 8'(4 * i), rv[i]);
			wr(8'h20 + 8'(4 * i), 8'hFF);
			rd_chk(8'h20 + 8'(4 * i), mk[i]);
			wr(8'h20 + 8'(4 * i), rv[i]);
		end
		wr(8'h04, 8'hFF);
		rd_chk(8'h04, 8'h00);
		for (int i = 0; i < 4; i++) begin
			wr(8'h20, 8'h04 | (i[1] ? 8'h10 : 8'h00) |
				(i[0] ? 8'h02 : 8'h00));
			chk_val(32'(tdm_slot_bits), i[1] ? 32'h10 : 32'h20);
			chk_val(32'(oversample_ratio), i[0] ? 32'h80 : 32'h100);
		end
		for (int k = 0; k < 12; k++) begin
			wr(8'h24, (k < 8) ? 8'(1 << k) : 8'h00);
			wr(8'h28, (k >= 8) ? 8'(1 << (k - 8)) : 8'h00);
			smp(4'(k), 24'h001234, 24'h000000);
			smp(4'((k + 1) % 12), 24'h001234, 24'h001234);
		end
		wr(8'h28, 8'h00);
		zrun(4'h0, 1024);
		zrun(4'h1, 1023);
		rd_chk(8'h80, 8'h01);
		smp(4'h1, 24'h000005, 24'h000005);
		smp(4'h0, 24'h000005, 24'h000000);
		smp(4'h0, 24'h000005, 24'h000005);
		wr(8'h20, 8'h00);
		zrun(4'h2, 1024);
		smp(4'h2, 24'h000005, 24'h000005);
		wr(8'h20, 8'h08);
		smp(4'h4, 24'h0003E8, 24'hFFFC18);
		smp(4'h7, 24'h800000, 24'h7FFFFF);
		wr(8'h20, 8'h00);
		zrun(4'h3, 40);
		wr(8'h20, 8'h01);
		smp(4'h3, 24'h000FA0, 24'h0003E8);
		wr(8'h20, 8'h00);
		wr(8'h2C, 8'h80);
		wr(8'h30, 8'h70);
		smp(4'h0, 24'h7FFFFF, 24'h0000FF);
		wr(8'h30, 8'h90);
		smp(4'h0, 24'h7FFFFF, 24'h000086);
		smp(4'h5, 24'h7FFFFF, 24'h007FFF);
		wr(8'h2C, 8'h10);
		smp(4'h5, 24'h001000, 24'h000800);
		wr(8'h2C, 8'h00);
		wr(8'h34, 8'h10);
		smp(4'h1, 24'h001000, 24'h000800);
		frz_wr(8'h2C, 8'h55);
		rd_chk(8'h2C, 8'h55);
		avs_byteenable <= 4'hE;
		wr(8'h2C, 8'hAA);
		avs_byteenable <= 4'hF;
		rd_chk(8'h2C, 8'h55);
		test_done();
	end
endmodule : dacoc_regs_tb

bind dacoc_regs dacoc_mon #(.NCH(NCH)) u_mon (.ref_clk(ref_clk),
	.sys_rst(sys_rst), .clk_en(clk_en), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write),
	.avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.in_valid(in_valid), .in_ch(in_ch), .in_data(in_data),
	.out_valid(out_valid), .out_ch(out_ch), .out_data(out_data),
	.tdm_slot_bits(tdm_slot_bits), .oversample_ratio(oversample_ratio));
